// ===== src/qdbr_defines.svh
`ifndef QDBR_DEFINES_SVH
`define QDBR_DEFINES_SVH

// Register byte offsets on the APB slave.
`define QDBR_OFF_TASKFILE   8'h00
`define QDBR_OFF_COMMAND    8'h04
`define QDBR_OFF_CONTROL    8'h08
`define QDBR_OFF_CONDITION  8'h0C
`define QDBR_OFF_ERROR      8'h10
`define QDBR_OFF_DATA       8'h14
`define QDBR_OFF_BUF_FILL   8'h18
`define QDBR_OFF_STRICT     8'h1C

// Command opcodes, the deadline subcommand code and the isochronous priority class.
`define QDBR_OP_QUEUE_MGMT  8'h63
`define QDBR_OP_READ_BUF    8'hE4
`define QDBR_OP_WRITE_BUF   8'hE8
`define QDBR_SUB_DEADLINE   4'h1
`define QDBR_PRIORITY_CLASS_ISOCH     2'h1

// Field positions inside the taskfile, the feature byte and the control register.
`define QDBR_TF_FEATURE_LSB 0
`define QDBR_TF_COUNT_LSB   8
`define QDBR_TF_NUMBER_LSB  16
`define QDBR_FEAT_WSTRICT   4
`define QDBR_FEAT_RSTRICT   5
`define QDBR_SLOT_LSB       3
`define QDBR_CTL_NCQ_EN     0
`define QDBR_CTL_MAXTAG_LSB 8
`define QDBR_CTL_DL_SUPP    16

// Bit positions in the condition and error-cause bytes.
`define QDBR_ST_BUSY        7
`define QDBR_ST_READY       6
`define QDBR_ST_FAULT       5
`define QDBR_ST_SEEKDONE    4
`define QDBR_ST_DRQ         3
`define QDBR_ST_ERR         0
`define QDBR_ER_ABORTED     2

// Reset values.
`define QDBR_RST_CONDITION  8'h50
`define QDBR_RST_ERROR      8'h00
`define QDBR_RST_MAX_TAG    5'h1F
`define QDBR_RST_NCQ_EN     1'b0
`define QDBR_RST_DL_SUPP    1'b1

`endif

// ===== src/qdbr_pkg.sv
package qdbr_pkg;

    // Command engine states.
    typedef enum logic [1:0] {
        st_idle,
        st_exec,
        st_xfer
    } qdbr_state_t;

endpackage : qdbr_pkg

// ===== src/qdbr_core.sv
`timescale 1ns/10ps
`include "qdbr_defines.svh"

module qdbr_core #(
    parameter int SECTOR_WORDS = 256
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    input  wire logic        qcmd_late,
    input  wire logic        qcmd_is_write,
    input  wire logic [1:0]  qcmd_priority_class,
    output logic             sdb_send,
    output logic [4:0]       sdb_tag,
    output logic             abort_outstanding
);

    localparam int PW = $clog2(SECTOR_WORDS);

    typedef struct packed {
        qdbr_pkg::qdbr_state_t state;
        logic [7:0]            opcode;
        logic [7:0]            feature;
        logic [7:0]            count;
        logic [7:0]            number;
        logic                  ncq_en;
        logic                  dl_supported;
        logic [4:0]            max_tag;
        logic                  write_strict;
        logic                  read_strict;
        logic [7:0]            condition;
        logic [7:0]            error_cause;
        logic [PW-1:0]         rd_ptr;
        logic [PW-1:0]         fill_ptr;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
        logic                  sdb_send;
        logic [4:0]            sdb_tag;
        logic                  abort_all;
    } qdbr_regs_t;

    qdbr_regs_t r_reg;
    qdbr_regs_t r_next;
    logic [15:0] sector_buf [SECTOR_WORDS];

    // True for every offset that the slave decodes.
    function automatic logic addr_known(input logic [7:0] a);
        return (a == `QDBR_OFF_TASKFILE) || (a == `QDBR_OFF_COMMAND) ||
               (a == `QDBR_OFF_CONTROL)  || (a == `QDBR_OFF_CONDITION) ||
               (a == `QDBR_OFF_ERROR)    || (a == `QDBR_OFF_DATA) ||
               (a == `QDBR_OFF_BUF_FILL) || (a == `QDBR_OFF_STRICT);
    endfunction : addr_known

    // A slot number is valid only up to the reported queue depth.
    function automatic logic slot_ok(input logic [4:0] slot, input logic [4:0] max_tag);
        return slot <= max_tag;
    endfunction : slot_ok

    // Builds a condition byte; ready always shows, seek-done only when not busy, fault never.
    function automatic logic [7:0] cond_word(input logic busy, input logic drq,
                                             input logic err);
        logic [7:0] c;
        c = 8'h00;
        c[`QDBR_ST_BUSY]     = busy;
        c[`QDBR_ST_READY]    = 1'b1;
        c[`QDBR_ST_SEEKDONE] = ~busy;
        c[`QDBR_ST_DRQ]      = drq;
        c[`QDBR_ST_ERR]      = err;
        return c;
    endfunction : cond_word

    logic        setup_ph;
    logic        access_ph;
    logic        buf_wr;
    logic [4:0]  cmd_slot;
    logic [4:0]  target_slot;
    logic        is_deadline;
    logic        dl_reject;

    assign setup_ph    = psel & ~penable;
    assign access_ph   = psel & penable & r_reg.pready;
    assign buf_wr      = access_ph & pwrite & ~r_reg.pslverr &
                         (paddr == `QDBR_OFF_BUF_FILL);
    assign cmd_slot    = r_reg.count[7:`QDBR_SLOT_LSB];
    assign target_slot = r_reg.number[7:`QDBR_SLOT_LSB];
    // Opcode and low feature nibble together pick the deadline subcommand.
    assign is_deadline = (r_reg.opcode == `QDBR_OP_QUEUE_MGMT) &&
                         (r_reg.feature[3:0] == `QDBR_SUB_DEADLINE);
    // Any one of these conditions turns the deadline subcommand into an abort.
    assign dl_reject   = !r_reg.dl_supported || !r_reg.ncq_en ||
                         (target_slot == cmd_slot) ||
                         !slot_ok(target_slot, r_reg.max_tag) ||
                         (r_reg.feature[7:6] != 2'h0);

    // Buffer write port; memory has no reset so it maps onto plain RAM.
    // No media path shares this buffer, so a read returns the last fill unchanged.
    always_ff @(posedge pclk) begin
        if (buf_wr) begin
            sector_buf[r_reg.fill_ptr] <= pwdata[15:0];
        end
    end

    // Next-state logic for the whole block.
    always_comb begin
        r_next           = r_reg;
        r_next.pready    = 1'b0;
        r_next.sdb_send  = 1'b0;
        r_next.abort_all = 1'b0;

        // Setup phase: decide the answer and prepare read data one cycle ahead.
        if (setup_ph) begin
            r_next.pready  = 1'b1;
            r_next.pslverr = ~addr_known(paddr);
            r_next.prdata  = 32'h0000_0000;
            unique case (paddr)
                `QDBR_OFF_TASKFILE: begin
                    r_next.prdata = {8'h00, r_reg.number, r_reg.count, r_reg.feature};
                end
                `QDBR_OFF_CONTROL: begin
                    r_next.prdata[`QDBR_CTL_NCQ_EN]                       = r_reg.ncq_en;
                    r_next.prdata[`QDBR_CTL_MAXTAG_LSB +: 5]             = r_reg.max_tag;
                    r_next.prdata[`QDBR_CTL_DL_SUPP]                      = r_reg.dl_supported;
                end
                `QDBR_OFF_CONDITION: begin
                    r_next.prdata[7:0] = r_reg.condition;
                end
                `QDBR_OFF_ERROR: begin
                    r_next.prdata[7:0] = r_reg.error_cause;
                end
                `QDBR_OFF_DATA: begin
                    // Data reads zero outside a transfer so a stray read is harmless.
                    if (r_reg.state == qdbr_pkg::st_xfer) begin
                        r_next.prdata[15:0] = sector_buf[r_reg.rd_ptr];
                    end
                end
                `QDBR_OFF_STRICT: begin
                    r_next.prdata[1:0] = {r_reg.read_strict, r_reg.write_strict};
                end
                default: begin
                    r_next.prdata = 32'h0000_0000;
                end
            endcase
        end

        // Access phase: writes take effect and data reads advance the pointer.
        if (access_ph && !r_reg.pslverr) begin
            if (pwrite) begin
                unique case (paddr)
                    `QDBR_OFF_TASKFILE: begin
                        // The taskfile is frozen while a command runs.
                        if (r_reg.state == qdbr_pkg::st_idle) begin
                            r_next.feature = pwdata[`QDBR_TF_FEATURE_LSB +: 8];
                            r_next.count   = pwdata[`QDBR_TF_COUNT_LSB +: 8];
                            r_next.number  = pwdata[`QDBR_TF_NUMBER_LSB +: 8];
                        end
                    end
                    `QDBR_OFF_COMMAND: begin
                        if (r_reg.state == qdbr_pkg::st_idle) begin
                            r_next.opcode    = pwdata[7:0];
                            r_next.state     = qdbr_pkg::st_exec;
                            r_next.condition = cond_word(1'b1, 1'b0, 1'b0);
                        end
                    end
                    `QDBR_OFF_CONTROL: begin
                        r_next.ncq_en       = pwdata[`QDBR_CTL_NCQ_EN];
                        r_next.max_tag      = pwdata[`QDBR_CTL_MAXTAG_LSB +: 5];
                        r_next.dl_supported = pwdata[`QDBR_CTL_DL_SUPP];
                    end
                    `QDBR_OFF_BUF_FILL: begin
                        r_next.fill_ptr = r_reg.fill_ptr + PW'(1);
                    end
                    default: begin
                        r_next.pslverr = r_reg.pslverr;
                    end
                endcase
            end else if (paddr == `QDBR_OFF_DATA && r_reg.state == qdbr_pkg::st_xfer) begin
                // One 16-bit word leaves per data read until the sector is out.
                r_next.rd_ptr = r_reg.rd_ptr + PW'(1);
                if (r_reg.rd_ptr == PW'(SECTOR_WORDS - 1)) begin
                    r_next.state     = qdbr_pkg::st_idle;
                    r_next.condition = cond_word(1'b0, 1'b0, 1'b0);
                end
            end
        end

        // Command execution takes one cycle with busy shown meanwhile.
        unique case (r_reg.state)
            qdbr_pkg::st_idle: begin
            end
            qdbr_pkg::st_exec: begin
                r_next.state = qdbr_pkg::st_idle;
                if (is_deadline && !dl_reject) begin
                    // Strict bits latch only when the subcommand is accepted.
                    r_next.write_strict = r_reg.feature[`QDBR_FEAT_WSTRICT];
                    r_next.read_strict  = r_reg.feature[`QDBR_FEAT_RSTRICT];
                    r_next.condition    = cond_word(1'b0, 1'b0, 1'b0);
                    r_next.error_cause  = 8'h00;
                    r_next.sdb_send     = 1'b1;
                    r_next.sdb_tag      = cmd_slot;
                end else if (r_reg.opcode == `QDBR_OP_READ_BUF) begin
                    // Reads start at the same origin that buffer fills start from.
                    r_next.rd_ptr      = '0;
                    r_next.state       = qdbr_pkg::st_xfer;
                    r_next.condition   = cond_word(1'b0, 1'b1, 1'b0);
                    r_next.error_cause = 8'h00;
                end else if (r_reg.opcode == `QDBR_OP_WRITE_BUF) begin
                    // A buffer write rewinds the fill pointer to the sector origin.
                    r_next.fill_ptr    = '0;
                    r_next.condition   = cond_word(1'b0, 1'b0, 1'b0);
                    r_next.error_cause = 8'h00;
                end else begin
                    // Rejected deadline, other subcommands and unknown opcodes abort.
                    r_next.condition   = cond_word(1'b0, 1'b0, 1'b1);
                    r_next.error_cause = 8'h00;
                    r_next.error_cause[`QDBR_ER_ABORTED] = 1'b1;
                end
            end
            qdbr_pkg::st_xfer: begin
            end
        endcase

        // A late isochronous queued command under a strict bit aborts them all.
        if (qcmd_late && qcmd_priority_class == `QDBR_PRIORITY_CLASS_ISOCH &&
            (qcmd_is_write ? r_reg.write_strict : r_reg.read_strict)) begin
            r_next.abort_all   = 1'b1;
            r_next.condition[`QDBR_ST_ERR] = 1'b1;
            r_next.error_cause[`QDBR_ER_ABORTED] = 1'b1;
        end
    end

    // State register with constant reset values only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg              <= '0;
            r_reg.state        <= qdbr_pkg::st_idle;
            r_reg.ncq_en       <= `QDBR_RST_NCQ_EN;
            r_reg.dl_supported <= `QDBR_RST_DL_SUPP;
            r_reg.max_tag      <= `QDBR_RST_MAX_TAG;
            r_reg.condition    <= `QDBR_RST_CONDITION;
            r_reg.error_cause  <= `QDBR_RST_ERROR;
        end else begin
            r_reg <= r_next;
        end
    end

    assign pready            = r_reg.pready;
    assign pslverr           = r_reg.pslverr;
    assign prdata            = r_reg.prdata;
    assign sdb_send          = r_reg.sdb_send;
    assign sdb_tag           = r_reg.sdb_tag;
    assign abort_outstanding = r_reg.abort_all;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_deadline_sdb_sent: assert property (
        r_reg.state == qdbr_pkg::st_exec && is_deadline && !dl_reject |=>
        sdb_send && sdb_tag == $past(cmd_slot) && !r_reg.condition[`QDBR_ST_ERR])
        else $error("Accepted deadline subcommand did not complete cleanly.");

    chk_ncq_off_abort: assert property (
        r_reg.state == qdbr_pkg::st_exec && is_deadline && !r_reg.ncq_en |=>
        !sdb_send && r_reg.error_cause[`QDBR_ER_ABORTED])
        else $error("Deadline subcommand not aborted with queuing disabled.");

    chk_same_slot_abort: assert property (
        r_reg.state == qdbr_pkg::st_exec && is_deadline && target_slot == cmd_slot |=>
        !sdb_send ##0 r_reg.condition[`QDBR_ST_ERR])
        else $error("Target slot equal to own slot was not aborted.");

    chk_bad_slot_abort: assert property (
        r_reg.state == qdbr_pkg::st_exec && is_deadline && target_slot > r_reg.max_tag |=>
        r_reg.error_cause[`QDBR_ER_ABORTED])
        else $error("Invalid target slot was not aborted.");

    chk_abort_type_bad: assert property (
        r_reg.state == qdbr_pkg::st_exec && is_deadline && r_reg.feature[7:6] != 2'h0 |=>
        !sdb_send && r_reg.error_cause[`QDBR_ER_ABORTED])
        else $error("Unsupported abort type was not aborted.");

    chk_late_strict_abort: assert property (
        qcmd_late && qcmd_priority_class == `QDBR_PRIORITY_CLASS_ISOCH &&
        (qcmd_is_write ? r_reg.write_strict : r_reg.read_strict) |=> abort_outstanding)
        else $error("Late strict isochronous command did not abort all.");

    chk_late_lenient: assert property (
        !(qcmd_late && qcmd_priority_class == `QDBR_PRIORITY_CLASS_ISOCH &&
          (qcmd_is_write ? r_reg.write_strict : r_reg.read_strict)) |=> !abort_outstanding)
        else $error("Outstanding commands aborted without a strict deadline miss.");

    chk_buf_read_start: assert property (
        r_reg.state == qdbr_pkg::st_exec && !is_deadline &&
        r_reg.opcode == `QDBR_OP_READ_BUF |=>
        r_reg.state == qdbr_pkg::st_xfer && r_reg.rd_ptr == '0 &&
        r_reg.condition[`QDBR_ST_DRQ])
        else $error("Buffer read did not start at the sector origin.");

    chk_xfer_end_status: assert property (
        $fell(r_reg.state == qdbr_pkg::st_xfer) |->
        $past(r_reg.rd_ptr) == PW'(SECTOR_WORDS - 1) &&
        !r_reg.condition[`QDBR_ST_BUSY] && !r_reg.condition[`QDBR_ST_FAULT])
        else $error("Buffer read ended early or with busy or fault set.");

    chk_abort_err_bit: assert property (
        $rose(r_reg.error_cause[`QDBR_ER_ABORTED]) |-> r_reg.condition[`QDBR_ST_ERR])
        else $error("Aborted flag set without the error bit.");

endmodule : qdbr_core

// ===== tb/qdbr_host_model.sv
`timescale 1ns/10ps

// Host-side stand-in: it reports missed deadlines and counts the frames the device returns.
module qdbr_host_model (
    input  wire logic       pclk,
    input  wire logic       sdb_send,
    input  wire logic       abort_outstanding,
    output logic            qcmd_late,
    output logic            qcmd_is_write,
    output logic [1:0]      qcmd_priority_class
);
    int sdb_seen   = 0;
    int abort_seen = 0;

    // Quiet outputs from time zero onward.
    initial begin
        qcmd_late     = 1'b0;
        qcmd_is_write = 1'b0;
        qcmd_priority_class     = 2'h0;
    end

    // One-cycle miss report; the qualifiers are inverted afterwards so no stale class lingers.
    task automatic miss(input logic wr, input logic [1:0] priority_class);
        @(posedge pclk);
        qcmd_late     <= 1'b1;
        qcmd_is_write <= wr;
        qcmd_priority_class     <= priority_class;
        @(posedge pclk);
        qcmd_late     <= 1'b0;
        qcmd_is_write <= ~wr;
        qcmd_priority_class     <= ~priority_class;
    endtask : miss

    // Count completion frames and abort-all pulses seen from the device.
    always @(posedge pclk) begin
        if (sdb_send === 1'b1) sdb_seen++;
        if (abort_outstanding === 1'b1) abort_seen++;
    end
endmodule : qdbr_host_model

// ===== tb/queue_deadline_and_buffer_read_bench.sv
`timescale 1ns/10ps
`include "qdbr_defines.svh"

module queue_deadline_and_buffer_read_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        qcmd_late;
    logic        qcmd_is_write;
    logic [1:0]  qcmd_priority_class;
    logic        sdb_send;
    logic [4:0]  sdb_tag;
    logic        abort_outstanding;
    logic [33:0] exp_q[$];
    logic [4:0]  tag_q[$];
    logic [33:0] note;
    logic [31:0] seed = 32'h28;
    logic [15:0] words[8];
    logic [4:0]  s;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          exp_sdb = 0;
    int          exp_abort = 0;

    qdbr_core #(.SECTOR_WORDS(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .qcmd_late(qcmd_late),
        .qcmd_is_write(qcmd_is_write), .qcmd_priority_class(qcmd_priority_class), .sdb_send(sdb_send),
        .sdb_tag(sdb_tag), .abort_outstanding(abort_outstanding));

    qdbr_host_model u_host (.pclk(pclk), .sdb_send(sdb_send),
        .abort_outstanding(abort_outstanding), .qcmd_late(qcmd_late),
        .qcmd_is_write(qcmd_is_write), .qcmd_priority_class(qcmd_priority_class));

    // Free-running 100 ns clock.
    initial begin
        forever #50 pclk = ~pclk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    // One APB transfer; the expected answer is noted before the request goes out.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic chk, input logic err, input logic [31:0] exp);
        exp_q.push_back({chk, err, exp});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the slave however long it takes; only the watchdog ends a hang.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b1, 1'b0, exp);
    endtask : rd

    // Launch an opcode and let the busy cycle and the result cycle pass.
    task automatic cmd(input logic [7:0] op);
        apb(1'b1, `QDBR_OFF_COMMAND, {24'h0, op}, 1'b0, 1'b0, 32'h0);
        repeat (3) @(posedge pclk);
    endtask : cmd

    // Queue-management command with the given feature, own slot and target slot.
    task automatic dl(input logic [7:0] f, input logic [4:0] sl, input logic [4:0] tg,
                      input logic ok);
        apb(1'b1, `QDBR_OFF_TASKFILE, {8'h00, tg, 3'h0, sl, 3'h0, f}, 1'b0, 1'b0, 32'h0);
        if (ok) begin
            tag_q.push_back(sl);
            exp_sdb++;
        end
        cmd(`QDBR_OP_QUEUE_MGMT);
        rd(`QDBR_OFF_CONDITION, ok ? 32'h50 : 32'h51);
        rd(`QDBR_OFF_ERROR, ok ? 32'h00 : 32'h04);
        if (ok) rd(`QDBR_OFF_STRICT, {30'h0, f[5], f[4]});
    endtask : dl

    // Compare every answer against the oldest note and every completion frame against the oldest queued tag.
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            if (note[33]) check(prdata, note[31:0]);
            check({31'h0, pslverr}, {31'h0, note[32]});
        end
        if (sdb_send === 1'b1 && tag_q.size() > 0) begin
            check({27'h0, sdb_tag}, {27'h0, tag_q.pop_front()});
        end
    end

    // A hang is cut short well after the sequence should have ended.
    initial begin
        repeat (30000) @(posedge pclk);
        error_cnt++;
        results();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`QDBR_OFF_CONDITION, {24'h0, `QDBR_RST_CONDITION});
        rd(`QDBR_OFF_ERROR, {24'h0, `QDBR_RST_ERROR});
        rd(`QDBR_OFF_CONTROL, 32'h0001_1F00);
        rd(`QDBR_OFF_STRICT, 32'h0);
        apb(1'b0, 8'h20, 32'h0, 1'b1, 1'b1, 32'h0);
        apb(1'b1, 8'h24, 32'h1, 1'b0, 1'b1, 32'h0);
        dl(8'h01, 5'd1, 5'd2, 1'b0);
        apb(1'b1, `QDBR_OFF_CONTROL, 32'h0001_0701, 1'b0, 1'b0, 32'h0);
        rd(`QDBR_OFF_CONTROL, 32'h0001_0701);
        dl(8'h01, 5'd3, 5'd3, 1'b0);
        dl(8'h01, 5'd3, 5'd8, 1'b0);
        dl(8'h01, 5'd3, 5'd7, 1'b1);
        for (int t = 1; t < 4; t++) dl({t[1:0], 6'h01}, 5'd2, 5'd4, 1'b0);
        dl(8'h00, 5'd2, 5'd4, 1'b0);
        dl(8'h02, 5'd2, 5'd4, 1'b0);
        cmd(8'h25);
        rd(`QDBR_OFF_CONDITION, 32'h51);
        // Random slots, always unique against the target and inside the reported depth.
        for (int i = 0; i < 4; i++) begin
            s = {2'h0, 3'(xs() % 8)};
            dl({2'h0, seed[9:8], 4'h1}, s, {2'h0, 3'(s + 3'd1 + 3'(xs() % 7))}, 1'b1);
        end
        dl(8'h11, 5'd2, 5'd4, 1'b1);
        u_host.miss(1'b1, 2'h1);
        exp_abort++;
        repeat (3) @(posedge pclk);
        rd(`QDBR_OFF_CONDITION, 32'h51);
        rd(`QDBR_OFF_ERROR, 32'h04);
        u_host.miss(1'b1, 2'h2);
        u_host.miss(1'b0, 2'h1);
        dl(8'h21, 5'd6, 5'd0, 1'b1);
        u_host.miss(1'b0, 2'h1);
        exp_abort++;
        u_host.miss(1'b0, 2'h0);
        u_host.miss(1'b1, 2'h1);
        repeat (3) @(posedge pclk);
        check(32'(u_host.abort_seen), 32'(exp_abort));
        // Fill the buffer, then read the sector back word by word.
        cmd(`QDBR_OP_WRITE_BUF);
        for (int i = 0; i < 8; i++) begin
            words[i] = 16'(xs());
            apb(1'b1, `QDBR_OFF_BUF_FILL, {16'h0, words[i]}, 1'b0, 1'b0, 32'h0);
        end
        cmd(`QDBR_OP_READ_BUF);
        rd(`QDBR_OFF_CONDITION, 32'h58);
        for (int i = 0; i < 8; i++) rd(`QDBR_OFF_DATA, {16'h0, words[i]});
        rd(`QDBR_OFF_CONDITION, 32'h50);
        rd(`QDBR_OFF_ERROR, 32'h00);
        repeat (3) @(posedge pclk);
        check(32'(u_host.sdb_seen), 32'(exp_sdb));
        results();
    end
endmodule : queue_deadline_and_buffer_read_bench
